// *** core/ssp_pkg.sv ***
/*
 Register map, field positions, reset values and timing constants of the
 serial port data/status/prescale block. Assumes a 32-bit register port.
*/
package ssp_pkg;
   localparam logic [31:0] SSP_DATA_ADDR    = 32'h4004_0008;
   localparam logic [31:0] SSP_FLAGS_ADDR   = 32'h4004_000C;
   localparam logic [31:0] SSP_PREDIV_ADDR  = 32'h4004_0010;
   localparam logic [31:0] SSP_IEN_ADDR     = 32'h4004_0014;
   localparam logic [31:0] SSP_IRQ_ST_ADDR  = 32'h4004_0018;
   localparam logic [31:0] SSP_IRQ_CLR_ADDR = 32'h4004_0020;

   localparam int FLAG_TX_EMPTY = 0;
   localparam int FLAG_TX_ROOM  = 1;
   localparam int FLAG_RX_DATA  = 2;
   localparam int FLAG_RX_FULL  = 3;
   localparam int FLAG_ACTIVE   = 4;

   localparam int IRQ_OVERRUN   = 0;
   localparam int IRQ_TIMEOUT   = 1;
   localparam int IRQ_RX_HALF   = 2;
   localparam int IRQ_TX_HALF   = 3;

   localparam logic [7:0] PREDIV_RESET = 8'h00;
   localparam logic [3:0] IEN_RESET    = 4'h0;
   localparam logic [3:0] IRQ_RESET    = 4'h0;

   localparam int PREDIV_MIN   = 2;
   localparam int PREDIV_MAX   = 254;
   localparam int TIMEOUT_BITS = 32;
   localparam int TIMEOUT_EDGES = 2 * TIMEOUT_BITS;

   typedef enum logic {SSP_IDLE, SSP_SHIFT} ssp_state_t;
endpackage : ssp_pkg

// *** core/ssp_core.sv ***
/*
 Serial port data path: transmit and receive FIFOs, status flags, clock
 prescaler, master shifter (clock idle low, sample on rising edge) and
 interrupt logic. Assumes register strobes synchronous to sys_clk_i and
 frame length and rate factor held steady while frames are in flight.
*/
// Decided for this implementation: the plain strobed port.
// Contract
// R1 - software writes data only while transmit-room flag is one
// R2 - frame written into empty FIFO with idle shifter starts at once
// R3 - software right-aligns transmit frames shorter than sixteen bits
// R4 - data read with receive data present returns and removes oldest frame
// R5 - short received frames are bit-zero aligned, upper bits zero
// R6 - flag 0 means transmit FIFO empty, flag 1 zero only when full
// R7 - flag 2 means receive data present, flag 3 means receive FIFO full
// R8 - flag 4 high while shifting or transmit FIFO holds data
// R9 - status register is read only
// R10 - predivider is even 2..254, bit 0 reads zero, resets zero
// R11 - clock divided by predivider then by rate factor plus one gives bit clock
// R12 - enable bit 0 gates overrun; full FIFO overwrites newest frame
// R13 - enable bit 1 gates timeout after 32 unread bit periods
// R14 - enable bit 2 gates receive FIFO at least half full
// R15 - enable bit 3 gates transmit FIFO at least half empty
// R16 - bit rate is clock over predivider times rate factor plus one
// R17 - writing one to a clear bit clears overrun or timeout
// R18 - both FIFOs hold eight sixteen-bit frames, thresholds from depth
`timescale 1ns/1ps
module ssp_core
   import ssp_pkg::*;
#(
   parameter int DEPTH = 8,
   parameter int WIDTH = 16
)
(
   input  wire logic        sys_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic [31:0] reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [31:0] reg_rdata_o,
   input  wire logic [7:0]  serial_rate_factor_i,
   input  wire logic [4:0]  frame_bits_i,
   input  wire logic        miso_i,
   output logic             mosi_o,
   output logic             sclk_o,
   output logic             ssel_n_o,
   output logic             irq_o
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);
   localparam logic [AW:0] CNT_HALF = (AW + 1)'(DEPTH / 2); // R18
   localparam logic [6:0]  TO_LAST  = 7'(TIMEOUT_EDGES - 1);

   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 4 || WIDTH > 16)
   begin : g_param_check
      $error("ssp_core: DEPTH must be a power of two, WIDTH 4..16");
   end

   logic [WIDTH-1:0] tx_mem [DEPTH];
   logic [WIDTH-1:0] rx_mem [DEPTH];
   logic [AW-1:0]    tx_rd;
   logic [AW-1:0]    tx_wr;
   logic [AW:0]      tx_cnt;
   logic [AW-1:0]    rx_rd;
   logic [AW-1:0]    rx_wr;
   logic [AW:0]      rx_cnt;
   logic [7:0]       predivide_value;
   logic [3:0]       interrupt_enables;
   logic [3:0]       irq_status;
   logic [7:0]       pre_cnt;
   logic [7:0]       rate_cnt;
   logic [6:0]       to_cnt;
   ssp_state_t       state;
   logic [WIDTH-1:0] tx_shift;
   logic [WIDTH-1:0] rx_shift;
   logic [4:0]       bits_left;
   logic             sclk;

   logic tx_empty_flag;
   logic tx_fifo_room_flag;
   logic rx_fifo_has_data_flag;
   logic rx_fifo_full_flag;
   logic shifter_active_flag;
   logic [4:0] serial_fifo_flags;
   logic data_sel;
   logic tx_push;
   logic tx_pop;
   logic rx_pop;
   logic rx_push;
   logic rx_overrun;
   logic pre_tick;
   logic edge_tick;
   logic timeout_hit;
   logic [3:0] irq_events;
   logic [3:0] irq_clear;
   logic [3:0] next_irq_status;

   assign data_sel              = (reg_addr_i == SSP_DATA_ADDR);
   assign tx_empty_flag         = (tx_cnt == '0); // R6
   assign tx_fifo_room_flag     = (tx_cnt != CNT_FULL); // R6
   assign rx_fifo_has_data_flag = (rx_cnt != '0); // R7
   assign rx_fifo_full_flag     = (rx_cnt == CNT_FULL); // R7
   assign shifter_active_flag   = (state == SSP_SHIFT) || !tx_empty_flag; // R8
   assign serial_fifo_flags     = {shifter_active_flag, rx_fifo_full_flag,
                                   rx_fifo_has_data_flag, tx_fifo_room_flag,
                                   tx_empty_flag};

   // writes while full are dropped; software is expected to test room first
   assign tx_push = reg_wr_i && data_sel && tx_fifo_room_flag; // R1
   assign tx_pop  = (state == SSP_IDLE) && !tx_empty_flag; // R2
   assign rx_pop  = reg_rd_i && data_sel && rx_fifo_has_data_flag; // R4

   always_ff @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
      begin
         tx_rd  <= '0;
         tx_wr  <= '0;
         tx_cnt <= '0;
      end
      else
      begin
         if (tx_push)
         begin
            tx_mem[tx_wr] <= reg_wdata_i[WIDTH-1:0];
            tx_wr         <= tx_wr + 1'b1;
         end
         if (tx_pop)
            tx_rd <= tx_rd + 1'b1;
         if (tx_push && !tx_pop)
            tx_cnt <= tx_cnt + 1'b1;
         else if (tx_pop && !tx_push)
            tx_cnt <= tx_cnt - 1'b1;
      end
   end

   // full FIFO with no pop this cycle: newest entry is overwritten
   assign rx_overrun = rx_push && rx_fifo_full_flag && !rx_pop; // R12

   always_ff @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
      begin
         rx_rd  <= '0;
         rx_wr  <= '0;
         rx_cnt <= '0;
      end
      else
      begin
         if (rx_overrun)
            rx_mem[rx_wr - 1'b1] <= rx_shift; // R12
         else if (rx_push)
         begin
            rx_mem[rx_wr] <= rx_shift;
            rx_wr         <= rx_wr + 1'b1;
         end
         if (rx_pop)
            rx_rd <= rx_rd + 1'b1; // R4
         if (rx_push && !rx_overrun && !rx_pop)
            rx_cnt <= rx_cnt + 1'b1;
         else if (rx_pop && !rx_push)
            rx_cnt <= rx_cnt - 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
         predivide_value <= PREDIV_RESET; // R10
      else if (reg_wr_i && reg_addr_i == SSP_PREDIV_ADDR)
         predivide_value <= {reg_wdata_i[7:1], 1'b0}; // R10
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
         interrupt_enables <= IEN_RESET; // R15
      else if (reg_wr_i && reg_addr_i == SSP_IEN_ADDR)
         interrupt_enables <= reg_wdata_i[3:0];
   end

   // half-period ticks: predivide/2 clocks, so two edges take the full divisor;
   // a divisor below 2 stops the bit clock altogether;
   // >= rather than ==: a smaller divisor or factor written mid-count
   // takes effect at once instead of waiting for an 8-bit wrap
   assign pre_tick  = (predivide_value[7:1] != 7'h00) &&
                      (pre_cnt >= {1'b0, predivide_value[7:1]} - 8'h01); // R11
   assign edge_tick = pre_tick && (rate_cnt >= serial_rate_factor_i); // R16

   always_ff @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
      begin
         pre_cnt  <= 8'h00;
         rate_cnt <= 8'h00;
      end
      else
      begin
         pre_cnt <= pre_tick ? 8'h00 : pre_cnt + 8'h01; // R11
         if (edge_tick)
            rate_cnt <= 8'h00;
         else if (pre_tick)
            rate_cnt <= rate_cnt + 8'h01; // R16
      end
   end

   assign rx_push = (state == SSP_SHIFT) && edge_tick && sclk && (bits_left == 5'h01);

   always_ff @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
      begin
         state     <= SSP_IDLE;
         tx_shift  <= '0;
         rx_shift  <= '0;
         bits_left <= 5'h00;
         sclk      <= 1'b0;
      end
      else
      begin
         case (state)
            SSP_IDLE:
            begin
               if (tx_pop)
               begin
                  // left-align so the first bit out is always the top flop
                  tx_shift  <= tx_mem[tx_rd] << (5'(WIDTH) - frame_bits_i); // R3
                  rx_shift  <= '0; // R5
                  bits_left <= frame_bits_i;
                  state     <= SSP_SHIFT; // R2
               end
            end
            SSP_SHIFT:
            begin
               if (edge_tick)
               begin
                  sclk <= !sclk;
                  if (!sclk)
                     rx_shift <= {rx_shift[WIDTH-2:0], miso_i}; // R5
                  else if (bits_left == 5'h01)
                     state <= SSP_IDLE;
                  else
                  begin
                     tx_shift  <= tx_shift << 1;
                     bits_left <= bits_left - 5'h01;
                  end
               end
            end
            default:
               state <= SSP_IDLE;
         endcase
      end
   end

   assign mosi_o   = tx_shift[WIDTH-1];
   assign sclk_o   = sclk;
   assign ssel_n_o = (state != SSP_SHIFT);

   // timeout counts clock edges, two per bit, while unread data waits
   assign timeout_hit = edge_tick && (to_cnt == TO_LAST) && rx_fifo_has_data_flag; // R13

   always_ff @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
         to_cnt <= 7'h00;
      else if (!rx_fifo_has_data_flag || rx_pop)
         to_cnt <= 7'h00;
      else if (edge_tick && to_cnt <= TO_LAST)
         to_cnt <= to_cnt + 7'h01; // R13
   end

   assign irq_events[IRQ_OVERRUN] = rx_overrun; // R12
   assign irq_events[IRQ_TIMEOUT] = timeout_hit; // R13
   assign irq_events[IRQ_RX_HALF] = (rx_cnt >= CNT_HALF); // R14
   assign irq_events[IRQ_TX_HALF] = ((CNT_FULL - tx_cnt) >= CNT_HALF); // R15
   assign irq_clear = (reg_wr_i && reg_addr_i == SSP_IRQ_CLR_ADDR) ?
                      reg_wdata_i[3:0] : 4'h0;
   // a new event wins over a clear in the same cycle
   assign next_irq_status = (irq_status & ~irq_clear) | irq_events; // R17

   always_ff @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
         irq_status <= IRQ_RESET;
      else
         irq_status <= next_irq_status;
   end

   assign irq_o = |(irq_status & interrupt_enables); // R12

   // read data lives for exactly the cycle after the strobe
   always_ff @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
         reg_rdata_o <= 32'h0000_0000;
      else if (!reg_rd_i)
         reg_rdata_o <= 32'h0000_0000;
      else
      begin
         case (reg_addr_i)
            SSP_DATA_ADDR:
               reg_rdata_o <= rx_fifo_has_data_flag ?
                              32'(rx_mem[rx_rd]) : 32'h0000_0000; // R4
            SSP_FLAGS_ADDR:  reg_rdata_o <= 32'(serial_fifo_flags); // R9
            SSP_PREDIV_ADDR: reg_rdata_o <= {24'h00_0000, predivide_value};
            SSP_IEN_ADDR:    reg_rdata_o <= {28'h000_0000, interrupt_enables};
            SSP_IRQ_ST_ADDR: reg_rdata_o <= {28'h000_0000, irq_status};
            default:         reg_rdata_o <= 32'h0000_0000;
         endcase
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);

   chk_tx_flags: assert property // R6
      (tx_push && tx_empty_flag |=> !tx_empty_flag && tx_fifo_room_flag)
      else $error("transmit flags wrong after first write");
   chk_tx_full: assert property // R6
      (tx_push && !tx_pop && tx_cnt == CNT_FULL - 1'b1 |=> !tx_fifo_room_flag && !tx_empty_flag)
      else $error("room flag still high with transmit FIFO full");
   chk_rx_upper_zero: assert property // R5
      (rx_push && frame_bits_i < 5'(WIDTH) |-> (rx_shift >> frame_bits_i) == '0)
      else $error("short received frame has upper bits set");
   chk_rx_flags: assert property // R7
      (rx_push && !rx_overrun && !rx_pop |=> rx_fifo_has_data_flag)
      else $error("receive data flag low after a frame arrived");
   chk_busy_flag: assert property // R8
      (tx_push |=> shifter_active_flag [*2])
      else $error("busy flag low right after a transmit write");
   chk_prediv_lsb: assert property // R10
      (reg_wr_i && reg_addr_i == SSP_PREDIV_ADDR |=> predivide_value[0] == 1'b0
       && predivide_value[7:1] == $past(reg_wdata_i[7:1]))
      else $error("predivider not stored even");
   chk_start_now: assert property // R2
      ((state == SSP_IDLE) && !tx_empty_flag |=> (state == SSP_SHIFT) && !ssel_n_o)
      else $error("queued frame did not start at once");
   chk_rx_pop: assert property // R4
      (rx_pop && !rx_push |=> rx_cnt == $past(rx_cnt) - 1'b1)
      else $error("receive read did not remove a frame");
   chk_flags_ro: assert property // R9
      (reg_wr_i && reg_addr_i == SSP_FLAGS_ADDR && state == SSP_IDLE && tx_empty_flag
       && !rx_push |=> $stable(serial_fifo_flags))
      else $error("write to status changed a flag");
   chk_edge_rate: assert property // R16
      (edge_tick && predivide_value == 8'h02 && serial_rate_factor_i == 8'h00
       && $stable(predivide_value) |=> edge_tick)
      else $error("edge spacing wrong for minimum divisor");
   chk_ovr_set: assert property // R12
      (rx_overrun |=> irq_status[IRQ_OVERRUN] && rx_cnt == CNT_FULL)
      else $error("overrun not latched");
   chk_timeout_set: assert property // R13
      (timeout_hit |=> irq_status[IRQ_TIMEOUT])
      else $error("timeout not latched");
   chk_rx_half: assert property // R14
      (rx_cnt >= CNT_HALF |=> irq_status[IRQ_RX_HALF])
      else $error("receive half level not flagged");
   chk_tx_half: assert property // R15
      (tx_cnt <= CNT_HALF |=> irq_status[IRQ_TX_HALF])
      else $error("transmit half level not flagged");
   chk_clear_ovr: assert property // R17
      (reg_wr_i && reg_addr_i == SSP_IRQ_CLR_ADDR && reg_wdata_i[IRQ_OVERRUN]
       && !rx_overrun |=> !irq_status[IRQ_OVERRUN])
      else $error("overrun clear ignored");

   cov_frame_done: cover property (rx_push);
   cov_overrun:    cover property (rx_overrun);
   cov_timeout:    cover property (timeout_hit);
   cov_tx_full:    cover property (tx_cnt == CNT_FULL);
   cov_rx_full:    cover property (rx_fifo_full_flag);
endmodule : ssp_core

// *** tb/ssp_spi_slave.sv ***
/*
 Serial slave model for the far side of the link, clock idle low, data
 sampled on rising edges. Assumes select and clock come from the block.
*/
`timescale 1ns/1ps
module ssp_spi_slave (
   input  wire logic        sclk_i,
   input  wire logic        mosi_i,
   input  wire logic        ssel_n_i,
   input  wire logic [4:0]  frame_bits_i,
   output logic             miso_o,
   output logic [15:0]      got_o,
   output int               count_o
);
   logic [15:0] rep;
   logic [15:0] sh;
   int          idx = -1;

   initial
   begin
      miso_o  = 1'b0;
      got_o   = 16'h0;
      count_o = 0;
   end

   // reply differs per frame so reordering or loss shows up
   always @(negedge ssel_n_i)
   begin
      rep    = 16'hC3A0 + 16'(count_o);
      idx    = int'(frame_bits_i) - 1;
      sh     = 16'h0;
      miso_o = rep[idx];
   end

   always @(posedge sclk_i)
      if (ssel_n_i === 1'b0)
         sh = {sh[14:0], mosi_i};

   always @(negedge sclk_i)
      if (ssel_n_i === 1'b0 && idx > 0)
      begin
         idx--;
         miso_o = rep[idx];
      end

   // released line: inverse of last bit, never a held value
   always @(posedge ssel_n_i)
      if (idx == 0)
      begin
         got_o  = sh;
         count_o++;
         idx    = -1;
         miso_o = ~miso_o;
      end
endmodule : ssp_spi_slave

// *** tb/ssp_data_status_prescale_tb_top.sv ***
/*
 Self-checking bench for ssp_core: register bus tasks and scenarios.
 Assumes the slave model on the serial side and one 50 MHz clock.
*/
`timescale 1ns/1ps
module ssp_data_status_prescale_tb_top
   import ssp_pkg::*;
;
   logic        sys_clk, reset_n, reg_wr, reg_rd, miso, mosi, sclk, ssel_n, irq;
   logic        sclk_q;
   logic [31:0] reg_addr, reg_wdata, reg_rdata, v;
   logic [7:0]  rate_factor;
   logic [4:0]  frame_bits;
   logic [15:0] slave_got;
   int          slave_cnt, num_errors, tests_run, cyc, last_rise, sclk_per, c0;

   ssp_core u_ssp_core (
      .sys_clk_i            (sys_clk),
      .reset_n_i            (reset_n),
      .reg_addr_i           (reg_addr),
      .reg_wdata_i          (reg_wdata),
      .reg_wr_i             (reg_wr),
      .reg_rd_i             (reg_rd),
      .reg_rdata_o          (reg_rdata),
      .serial_rate_factor_i (rate_factor),
      .frame_bits_i         (frame_bits),
      .miso_i               (miso),
      .mosi_o               (mosi),
      .sclk_o               (sclk),
      .ssel_n_o             (ssel_n),
      .irq_o                (irq)
   );

   ssp_spi_slave u_ssp_spi_slave (
      .sclk_i       (sclk),
      .mosi_i       (mosi),
      .ssel_n_i     (ssel_n),
      .frame_bits_i (frame_bits),
      .miso_o       (miso),
      .got_o        (slave_got),
      .count_o      (slave_cnt)
   );

   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // bit period on the wire, in system clocks
   always @(posedge sys_clk)
   begin
      cyc++;
      sclk_q <= sclk;
      if (sclk === 1'b1 && sclk_q === 1'b0)
      begin
         sclk_per = cyc - last_rise;
         last_rise = cyc;
      end
   end

   task automatic give_verdict();
      if (num_errors == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : give_verdict

   task automatic chk(input string name, input logic [31:0] exp, got);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // settle past the edge before looking at the level output, then
   // realign so the next request is driven at a rising edge
   task automatic chk_irq(input logic exp);
      #1 chk("irq", {31'h0, exp}, {31'h0, irq});
      @(posedge sys_clk);
   endtask : chk_irq

   task automatic wr(input logic [31:0] a, d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
      @(posedge sys_clk);
   endtask : wr

   task automatic rd(input logic [31:0] a);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      #1 v = reg_rdata;
      @(posedge sys_clk);
   endtask : rd

   task automatic rdchk(input string name, input logic [31:0] a, exp);
      rd(a);
      chk(name, exp, v);
   endtask : rdchk

   task automatic wait_flags(input logic [31:0] mask, val);
      int n;
      n = 0;
      rd(SSP_FLAGS_ADDR);
      while ((v & mask) !== val && n < 500)
      begin
         rd(SSP_FLAGS_ADDR);
         n++;
      end
      if ((v & mask) !== val)
      begin
         num_errors++;
         give_verdict();
      end
   endtask : wait_flags

   task automatic t_reset();
      chk_irq(1'b0);
      rdchk("flags", SSP_FLAGS_ADDR, 32'h03);
      rdchk("prediv", SSP_PREDIV_ADDR, 32'h0);
      rdchk("enables", SSP_IEN_ADDR, 32'h0);
      rdchk("empty read", SSP_DATA_ADDR, 32'h0);
   endtask : t_reset

   task automatic t_regs();
      wr(SSP_PREDIV_ADDR, 32'hFF);
      rdchk("prediv", SSP_PREDIV_ADDR, 32'hFE);
      wr(SSP_FLAGS_ADDR, 32'h1C);
      rdchk("flags", SSP_FLAGS_ADDR, 32'h03);
      rdchk("unmapped", 32'h4004_0030, 32'h0);
      wr(SSP_IEN_ADDR, 32'hFF);
      rdchk("enables", SSP_IEN_ADDR, 32'h0F);
      wr(SSP_IEN_ADDR, 32'h0);
   endtask : t_regs

   task automatic t_single();
      rate_factor <= 8'h01;
      c0 = slave_cnt;
      wr(SSP_PREDIV_ADDR, 32'h04);
      wr(SSP_DATA_ADDR, 32'hA5);
      rdchk("busy flags", SSP_FLAGS_ADDR, 32'h13);
      wait_flags(32'h1F, 32'h07);
      chk("sent", 32'hA5, {16'h0, slave_got});
      chk("bit period", 32'h8, 32'(sclk_per));
      rdchk("rx frame", SSP_DATA_ADDR, (32'hC3A0 + c0) & 32'hFF);
      rdchk("flags", SSP_FLAGS_ADDR, 32'h03);
   endtask : t_single

   task automatic t_burst();
      rate_factor <= 8'h00;
      frame_bits  <= 5'd16;
      wr(SSP_PREDIV_ADDR, 32'h02);
      c0 = slave_cnt;
      for (int i = 0; i < 10; i++)
      begin
         reg_addr  <= SSP_DATA_ADDR;
         reg_wdata <= 32'h1000 + i;
         reg_wr    <= 1'b1;
         @(posedge sys_clk);
      end
      reg_wr <= 1'b0;
      rdchk("full flags", SSP_FLAGS_ADDR, 32'h10);
      wait_flags(32'h19, 32'h09);
      chk("frames sent", 32'(c0 + 9), 32'(slave_cnt));
      chk("last sent", 32'h1008, {16'h0, slave_got});
      rd(SSP_IRQ_ST_ADDR);
      chk("irq status", 32'hD, v & 32'hD);
      wr(SSP_IEN_ADDR, 32'h1);
      chk_irq(1'b1);
      wr(SSP_IRQ_CLR_ADDR, 32'h1);
      rd(SSP_IRQ_ST_ADDR);
      chk("overrun cleared", 32'h0, v & 32'h1);
      chk_irq(1'b0);
      for (int i = 0; i < 8; i++)
         rdchk("rx fifo", SSP_DATA_ADDR, 32'hC3A0 + c0 + (i == 7 ? 8 : i));
      rdchk("drained flags", SSP_FLAGS_ADDR, 32'h03);
      wr(SSP_IRQ_CLR_ADDR, 32'hF);
      wr(SSP_IEN_ADDR, 32'h8);
      chk_irq(1'b1);
      wr(SSP_IEN_ADDR, 32'h4);
      chk_irq(1'b0);
   endtask : t_burst

   task automatic t_timeout();
      frame_bits <= 5'd8;
      wr(SSP_IEN_ADDR, 32'h2);
      c0 = slave_cnt;
      wr(SSP_DATA_ADDR, 32'h3C);
      wait_flags(32'h4, 32'h4);
      rd(SSP_IRQ_ST_ADDR);
      chk("early timeout", 32'h0, v & 32'h2);
      repeat (70) @(posedge sys_clk);
      rd(SSP_IRQ_ST_ADDR);
      chk("timeout", 32'h2, v & 32'h2);
      chk_irq(1'b1);
      rdchk("rx frame", SSP_DATA_ADDR, (32'hC3A0 + c0) & 32'hFF);
      wr(SSP_IRQ_CLR_ADDR, 32'h2);
      rd(SSP_IRQ_ST_ADDR);
      chk("timeout cleared", 32'h0, v & 32'h2);
      chk_irq(1'b0);
   endtask : t_timeout

   initial
   begin
      reset_n     = 1'b0;
      reg_wr      = 1'b0;
      reg_rd      = 1'b0;
      reg_addr    = 32'h0;
      reg_wdata   = 32'h0;
      rate_factor = 8'h00;
      frame_bits  = 5'd8;
      repeat (6) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      t_reset();
      t_regs();
      t_single();
      t_burst();
      t_timeout();
      give_verdict();
   end
endmodule : ssp_data_status_prescale_tb_top
